// ---- design/kbhp_host_port_ctrl.sv ----
// Keyboard host port controller: host data/status ports and serial channels
//
// Behaviour
// - Host sees a data port and a status/command port.
// - Chip select low; read/write strobe and A2 pick buffer, status or command.
// - Data port read drives output buffer and clears output-full.
// - Status port read drives status byte, changes no flag.
// - Data port write loads input buffer, clears command flag, sets input-full.
// - Command port write same as data write but sets command flag.
// - Output-full set on controller load, cleared only by host data read.
// - Input-full cleared by controller read, set by any host write.
// - Status bit 2 shows system flag: zero cold, one hot reset.
// - Status bit 4 is one while keyboard enabled, zero when inhibited.
// - First mode: bit 5 set on transmit timeout.
// - First mode: bit 6 set on receive timeout.
// - Bit 7 flags receive parity error; buffer gets FFh, full set, irq.
// - Frame: zero start, eight data LSB first, odd parity, one stop.
// - One status register; meaning depends on control register mode bit.
// - Serial receive/transmit use 8-bit timeout timer, duplicated for mouse.
// - Scratch RAM reached by 5-bit index, then data access.
// - Port 1 input only, port 2 output only.
// - Mode bit set gives first mode, clear gives keyboard-plus-mouse; resets set.
// - With enable bit 0 set, output buffer load raises keyboard interrupt.
// - Second mode: timeout sets bit 6; buffer gets FEh or FFh.
`timescale 1ns/1ps
module kbhp_host_port_ctrl #(
  parameter int NCH = 2,
  parameter int TICK_CYCLES = kbhp_pkg::TICK_CYC,
  parameter logic [7:0] TIMEOUT_TICKS = 8'(kbhp_pkg::TO_TICKS),
  parameter logic [7:0] RTS_HOLD_TICKS = 8'(kbhp_pkg::RTS_TICKS),
  parameter int RAM_AW = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire kbhp_pkg::kbhp_host_t host_i,
  output logic [7:0] host_d_o,
  output logic host_d_oe_n,
  input wire kbhp_pkg::kbhp_mcu_t mcu_i,
  input wire logic [RAM_AW-1:0] mcu_ram_idx,
  output logic [7:0] mcu_ibuf_data,
  output logic mcu_ibuf_cmd,
  output logic [7:0] mcu_status,
  output logic [NCH-1:0] mcu_tx_busy,
  output logic [7:0] mcu_ram_rdata,
  output logic [7:0] mcu_in_port,
  input wire logic [7:0] input_port,
  output logic [7:0] output_port,
  input wire logic [NCH-1:0] link_clk_i,
  output logic [NCH-1:0] link_clk_o,
  output logic [NCH-1:0] link_clk_oe_n,
  input wire logic [NCH-1:0] link_dat_i,
  output logic [NCH-1:0] link_dat_o,
  output logic [NCH-1:0] link_dat_oe_n,
  output logic kbd_irq_pin
);
  import kbhp_pkg::*;

  typedef struct packed {
    kbhp_host_t h0;
    kbhp_host_t h1;
    kbhp_host_t h2;
    kbhp_host_t hs;
    logic rd_prev;
    logic rd_a2;
    logic wr_prev;
    logic wr_a2;
    logic [7:0] wr_byte;
    logic [7:0] d_out;
    logic d_oe_n;
    logic [7:0] out_buf;
    logic [7:0] in_buf;
    logic out_buf_full;
    logic in_buf_full;
    logic cmd_flag;
    logic out_src_mouse;
    logic tx_timeout;
    logic rx_timeout;
    logic general_timeout;
    logic rx_parity_err;
    logic [7:0] kbd_control_reg;
    logic [7:0] mode_reg;
    logic [RAM_AW-1:0] ram_idx;
    logic [2:0][7:0] p1_sync;
    logic [7:0] p1_s;
    logic [7:0] output_port;
    logic [11:0] tick_cnt;
    logic kbd_irq;
    logic [7:0] status;
    logic [NCH-1:0] busy;
    kbhp_ch_t [NCH-1:0] ch;
  } kbhp_state_t;

  kbhp_state_t q, d;

  logic rd_act;
  logic wr_act;
  logic tick;
  logic at_mode;
  logic kbd_en;
  logic [11:0] settled;
  logic [11:0] p1_set;
  kbhp_ch_t c;
  logic fall;
  logic [9:0] nsh;
  logic [NCH-1:0] ev_ok;
  logic [NCH-1:0] ev_rx_parity_err;
  logic [NCH-1:0] ev_rxto;
  logic [NCH-1:0] ev_txto;
  logic [NCH-1:0][7:0] rx_byte;

  // ==========================================================
  // Scratch RAM
  kbhp_scratch_ram #(
    .AW(RAM_AW),
    .DW(8)
  ) u_ram (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(mcu_i.ram_wr),
    .addr(q.ram_idx),
    .wdata(mcu_i.wdata),
    .rdata(mcu_ram_rdata)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    d = q;
    c = '0;
    fall = 1'b0;
    nsh = '0;
    ev_ok = '0;
    ev_rx_parity_err = '0;
    ev_rxto = '0;
    ev_txto = '0;
    rx_byte = '0;

    // Host pins: three stages, settle on agreement
    d.h0 = host_i;
    d.h1 = q.h0;
    d.h2 = q.h1;
    settled = kbhp_settle(q.h1, q.h2, q.hs);
    d.hs = settled;
    d.p1_sync = {q.p1_sync[1:0], input_port};
    p1_set = kbhp_settle({4'h0, q.p1_sync[1]}, {4'h0, q.p1_sync[2]}, {4'h0, q.p1_s});
    d.p1_s = p1_set[7:0];

    at_mode = q.kbd_control_reg[CTRL_MODE];
    kbd_en = ~q.mode_reg[MODE_DKB] & (q.p1_s[P1_KEYLOCK] | q.mode_reg[MODE_INH]);

    // Timer prescaler
    tick = (q.tick_cnt == 12'(TICK_CYCLES - 1));
    d.tick_cnt = tick ? '0 : q.tick_cnt + 12'd1;

    // Host strobe decode
    rd_act = ~d.hs.cs_n & ~d.hs.ior_n & d.hs.iow_n;
    wr_act = ~d.hs.cs_n & d.hs.ior_n & ~d.hs.iow_n;
    d.rd_prev = rd_act;
    d.wr_prev = wr_act;
    if (rd_act)
    begin
      d.rd_a2 = d.hs.a2;
      d.d_oe_n = 1'b0;
      if (d.hs.a2 == KBHP_A2_STAT)
      begin
        d.d_out = q.status;
      end
      else
      begin
        d.d_out = q.out_buf;
      end
    end
    else
    begin
      d.d_oe_n = 1'b1;
    end
    if (wr_act)
    begin
      d.wr_a2 = d.hs.a2;
      d.wr_byte = d.hs.d;
    end

    // Controller side
    if (mcu_i.ibuf_rd)
    begin
      d.in_buf_full = 1'b0;
    end
    if (q.wr_prev && !wr_act)
    begin
      d.in_buf = q.wr_byte;
      d.in_buf_full = 1'b1;
      d.cmd_flag = (q.wr_a2 == KBHP_A2_STAT);
    end
    if (q.rd_prev && !rd_act && q.rd_a2 == KBHP_A2_DATA)
    begin
      d.out_buf_full = 1'b0;
    end
    if (mcu_i.mode_wr)
    begin
      d.mode_reg = mcu_i.wdata;
    end
    if (mcu_i.ctrl_wr)
    begin
      d.kbd_control_reg = mcu_i.wdata;
    end
    if (mcu_i.ram_idx_wr)
    begin
      d.ram_idx = mcu_ram_idx;
    end
    if (mcu_i.out_port_wr)
    begin
      d.output_port = mcu_i.wdata;
    end
    if (mcu_i.err_clr)
    begin
      d.tx_timeout = 1'b0;
      d.rx_timeout = 1'b0;
      d.general_timeout = 1'b0;
      d.rx_parity_err = 1'b0;
    end
    if (mcu_i.obuf_wr)
    begin
      d.out_buf = mcu_i.obuf_data;
      d.out_src_mouse = mcu_i.obuf_mouse;
      d.out_buf_full = 1'b1;
    end

    // Serial channels
    for (int i = 0; i < NCH; i++)
    begin
      c = q.ch[i];
      c.clk_sync = {q.ch[i].clk_sync[1:0], link_clk_i[i]};
      c.dat_sync = {q.ch[i].dat_sync[1:0], link_dat_i[i]};
      if (q.ch[i].clk_sync[1] == q.ch[i].clk_sync[2])
      begin
        c.clk_s = q.ch[i].clk_sync[2];
      end
      if (q.ch[i].dat_sync[1] == q.ch[i].dat_sync[2])
      begin
        c.dat_s = q.ch[i].dat_sync[2];
      end
      fall = q.ch[i].clk_s & ~c.clk_s;
      nsh = {c.dat_s, q.ch[i].shreg[9:1]};
      if (q.ch[i].st != CH_IDLE && tick)
      begin
        c.timer = q.ch[i].timer + 8'd1;
      end
      case (q.ch[i].st)
        CH_IDLE:
        begin
          c.timer = '0;
          c.bit_cnt = '0;
          if (mcu_i.tx_req[i])
          begin
            c.st = CH_RTS;
            c.clk_oe_n = 1'b0;
            c.shreg = {1'b1, ~^mcu_i.tx_data, mcu_i.tx_data};
          end
          else if (fall && !c.dat_s)
          begin
            c.st = CH_RX;
          end
        end
        CH_RX:
        begin
          if (fall)
          begin
            c.shreg = nsh;
            c.bit_cnt = q.ch[i].bit_cnt + 4'd1;
            if (q.ch[i].bit_cnt == LAST_SHIFT)
            begin
              c.st = CH_IDLE;
              rx_byte[i] = nsh[7:0];
              if (nsh[9] && (^nsh[8:0]))
              begin
                ev_ok[i] = 1'b1;
              end
              else
              begin
                ev_rx_parity_err[i] = 1'b1;
              end
            end
          end
          if (tick && q.ch[i].timer == TIMEOUT_TICKS - 8'd1)
          begin
            c.st = CH_IDLE;
            ev_rxto[i] = 1'b1;
          end
        end
        CH_RTS:
        begin
          if (tick && q.ch[i].timer == RTS_HOLD_TICKS - 8'd1)
          begin
            c.st = CH_TX;
            c.timer = '0;
            c.clk_oe_n = 1'b1;
            c.dat_oe_n = 1'b0;
          end
        end
        CH_TX:
        begin
          if (fall)
          begin
            c.dat_oe_n = q.ch[i].shreg[0];
            c.shreg = {1'b1, q.ch[i].shreg[9:1]};
            c.bit_cnt = q.ch[i].bit_cnt + 4'd1;
            if (q.ch[i].bit_cnt == LAST_SHIFT)
            begin
              c.st = CH_ACK;
            end
          end
          if (tick && q.ch[i].timer == TIMEOUT_TICKS - 8'd1)
          begin
            c.st = CH_IDLE;
            c.dat_oe_n = 1'b1;
            ev_txto[i] = 1'b1;
          end
        end
        CH_ACK:
        begin
          if (fall)
          begin
            c.st = CH_IDLE;
          end
          if (tick && q.ch[i].timer == TIMEOUT_TICKS - 8'd1)
          begin
            c.st = CH_IDLE;
            ev_txto[i] = 1'b1;
          end
        end
        default:
        begin
          c.st = CH_IDLE;
          c.clk_oe_n = 1'b1;
          c.dat_oe_n = 1'b1;
        end
      endcase
      d.ch[i] = c;
      d.busy[i] = (c.st != CH_IDLE);
    end

    // Channel events into the output buffer, lowest channel wins
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (ev_rx_parity_err[i])
      begin
        d.rx_parity_err = 1'b1;
        d.out_buf = FILL_RX_ERR;
        d.out_buf_full = 1'b1;
        d.out_src_mouse = (i != 0);
      end
      else if (ev_ok[i])
      begin
        d.out_buf = rx_byte[i];
        d.out_buf_full = 1'b1;
        d.out_src_mouse = (i != 0);
      end
      if (ev_rxto[i])
      begin
        if (at_mode)
        begin
          d.rx_timeout = 1'b1;
        end
        else
        begin
          d.general_timeout = 1'b1;
          d.out_buf = FILL_RX_ERR;
          d.out_buf_full = 1'b1;
          d.out_src_mouse = (i != 0);
        end
      end
      if (ev_txto[i])
      begin
        if (at_mode)
        begin
          d.tx_timeout = 1'b1;
        end
        else
        begin
          d.general_timeout = 1'b1;
          d.out_buf = FILL_TX_ERR;
          d.out_buf_full = 1'b1;
          d.out_src_mouse = (i != 0);
        end
      end
    end

    // Status byte and interrupt
    d.status[ST_OBF] = d.out_buf_full;
    d.status[ST_IBF] = d.in_buf_full;
    d.status[ST_SYS] = d.mode_reg[MODE_SYS];
    d.status[ST_CD] = d.cmd_flag;
    d.status[ST_KBD_ENABLED] = kbd_en;
    d.status[ST_B5] = d.kbd_control_reg[CTRL_MODE] ? d.tx_timeout : d.out_src_mouse;
    d.status[ST_B6] = d.kbd_control_reg[CTRL_MODE] ? d.rx_timeout : d.general_timeout;
    d.status[ST_RX_PARITY_ERR] = d.rx_parity_err;
    d.kbd_irq = d.mode_reg[MODE_EKI] & d.out_buf_full;
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.h0 <= '1;
      q.h1 <= '1;
      q.h2 <= '1;
      q.hs <= '1;
      q.d_oe_n <= 1'b1;
      q.kbd_control_reg <= CTRL_RST;
      q.mode_reg <= MODE_RST;
      q.output_port <= P2_RST;
      for (int i = 0; i < NCH; i++)
      begin
        q.ch[i].st <= CH_IDLE;
        q.ch[i].clk_sync <= '1;
        q.ch[i].dat_sync <= '1;
        q.ch[i].clk_s <= 1'b1;
        q.ch[i].dat_s <= 1'b1;
        q.ch[i].clk_oe_n <= 1'b1;
        q.ch[i].dat_oe_n <= 1'b1;
      end
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign host_d_o = q.d_out;
  assign host_d_oe_n = q.d_oe_n;
  assign mcu_ibuf_data = q.in_buf;
  assign mcu_ibuf_cmd = q.cmd_flag;
  assign mcu_status = q.status;
  assign mcu_tx_busy = q.busy;
  assign mcu_in_port = q.p1_s;
  assign output_port = q.output_port;
  assign kbd_irq_pin = q.kbd_irq;

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_link
      assign link_clk_o[g] = q.ch[g].shreg[0] & 1'b0;
      assign link_dat_o[g] = q.ch[g].shreg[0] & 1'b0;
      assign link_clk_oe_n[g] = q.ch[g].clk_oe_n;
      assign link_dat_oe_n[g] = q.ch[g].dat_oe_n;
    end
  endgenerate
endmodule

// ---- design/kbhp_pkg.sv ----
// Constants, types and helpers for the keyboard host port controller
package kbhp_pkg;

  // ==========================================================
  // Host port addresses and A2 decode
  localparam logic [7:0] KBHP_DATA_PORT = 8'h60;
  localparam logic [7:0] KBHP_CMD_PORT = 8'h64;
  localparam int KBHP_A2_BIT = 2;
  localparam logic KBHP_A2_DATA = KBHP_DATA_PORT[KBHP_A2_BIT];
  localparam logic KBHP_A2_STAT = KBHP_CMD_PORT[KBHP_A2_BIT];

  // ==========================================================
  // Status byte fields
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_SYS = 2;
  localparam int ST_CD = 3;
  localparam int ST_KBD_ENABLED = 4;
  localparam int ST_B5 = 5;
  localparam int ST_B6 = 6;
  localparam int ST_RX_PARITY_ERR = 7;

  // ==========================================================
  // Control and mode register fields, reset values
  localparam int CTRL_MODE = 1;
  localparam logic [7:0] CTRL_RST = 8'hc2;
  localparam int MODE_EKI = 0;
  localparam int MODE_SYS = 2;
  localparam int MODE_INH = 3;
  localparam int MODE_DKB = 4;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam int P1_KEYLOCK = 7;
  localparam logic [7:0] P2_RST = 8'h00;

  // ==========================================================
  // Error fill bytes and serial frame
  localparam logic [7:0] FILL_RX_ERR = 8'hff;
  localparam logic [7:0] FILL_TX_ERR = 8'hfe;
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] LAST_SHIFT = 4'(FRAME_BITS - 2);

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_TIMEOUT_US = 2000;
  localparam int RTS_HOLD_US = 100;
  localparam int TO_TICKS = (LINK_TIMEOUT_US * 1000) / TICK_NS;
  localparam int RTS_TICKS = (RTS_HOLD_US * 1000 + TICK_NS - 1) / TICK_NS;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic cs_n;
    logic ior_n;
    logic iow_n;
    logic a2;
    logic [7:0] d;
  } kbhp_host_t;

  typedef struct packed {
    logic obuf_wr;
    logic [7:0] obuf_data;
    logic obuf_mouse;
    logic ibuf_rd;
    logic mode_wr;
    logic ctrl_wr;
    logic [7:0] wdata;
    logic err_clr;
    logic [1:0] tx_req;
    logic [7:0] tx_data;
    logic ram_idx_wr;
    logic ram_wr;
    logic out_port_wr;
  } kbhp_mcu_t;

  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_RX = 3'b001,
    CH_RTS = 3'b010,
    CH_TX = 3'b011,
    CH_ACK = 3'b100
  } kbhp_ch_state_t;

  typedef struct packed {
    kbhp_ch_state_t st;
    logic [2:0] clk_sync;
    logic [2:0] dat_sync;
    logic clk_s;
    logic dat_s;
    logic [3:0] bit_cnt;
    logic [9:0] shreg;
    logic [7:0] timer;
    logic clk_oe_n;
    logic dat_oe_n;
  } kbhp_ch_t;

  // Per bit: take the new level once stages two and three agree
  function automatic logic [11:0] kbhp_settle(input logic [11:0] s1, input logic [11:0] s2,
                                               input logic [11:0] keep);
    return (s2 & ~(s1 ^ s2)) | (keep & (s1 ^ s2));
  endfunction

endpackage

// ---- design/kbhp_scratch_ram.sv ----
// Scratch RAM with registered read data
`timescale 1ns/1ps
module kbhp_scratch_ram #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  import kbhp_pkg::*;

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } kbhp_ram_st_t;

  kbhp_ram_st_t q, d;

  // ==========================================================
  // Write and registered read
  always_comb
  begin
    d = q;
    if (wr_en)
    begin
      d.mem[addr] = wdata;
    end
    d.rd = d.mem[addr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata = q.rd;
endmodule

// ---- dv/kbhp_host_port_ctrl_asserts.sv ----
// Port checker for the keyboard host port controller
`timescale 1ns/1ps
module kbhp_host_port_ctrl_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire kbhp_pkg::kbhp_host_t host_i,
  input wire logic [7:0] host_d_o,
  input wire logic host_d_oe_n,
  input wire kbhp_pkg::kbhp_mcu_t mcu_i,
  input wire logic [7:0] mcu_ibuf_data,
  input wire logic mcu_ibuf_cmd,
  input wire logic [7:0] mcu_status,
  input wire logic [7:0] output_port,
  input wire logic kbd_irq_pin
);
  import kbhp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Host bus
  rd_decode_a:
  assert property ($fell(host_d_oe_n) |-> !$past(host_i.cs_n, 2) && !$past(host_i.ior_n, 2))
    else $error("host drive without read strobe");
  status_value_a:
  assert property ($fell(host_d_oe_n) && host_i.a2 |-> host_d_o == mcu_status)
    else $error("status read value wrong");
  status_calm_a:
  assert property (!host_d_oe_n && host_i.a2 && mcu_i == '0 |=> $stable(mcu_status))
    else $error("status changed by status read");
  wr_capture_a:
  assert property ($rose(mcu_status[ST_IBF]) |->
    mcu_ibuf_cmd == $past(host_i.a2, 5) && mcu_ibuf_data == $past(host_i.d, 5))
    else $error("input buffer capture wrong");
  // ==========================================================
  // Flags
  obf_set_a:
  assert property (mcu_i.obuf_wr |=> mcu_status[ST_OBF])
    else $error("output full not set");
  obf_clear_a:
  assert property ($fell(mcu_status[ST_OBF]) |-> !$past(host_d_oe_n, 2))
    else $error("output full cleared without read");
  ibf_clear_a:
  assert property (mcu_i.ibuf_rd && host_i.iow_n && $past(host_i.iow_n, 5)
    |=> !mcu_status[ST_IBF])
    else $error("input full not cleared");
  irq_level_a:
  assert property (kbd_irq_pin |-> mcu_status[ST_OBF])
    else $error("irq without full buffer");
  out_port_a:
  assert property (mcu_i.out_port_wr |=> output_port == $past(mcu_i.wdata))
    else $error("output port not loaded");
endmodule

bind kbhp_host_port_ctrl kbhp_host_port_ctrl_asserts chk_u (
  .sys_clk(sys_clk), .rst(rst), .host_i(host_i), .host_d_o(host_d_o),
  .host_d_oe_n(host_d_oe_n), .mcu_i(mcu_i), .mcu_ibuf_data(mcu_ibuf_data),
  .mcu_ibuf_cmd(mcu_ibuf_cmd), .mcu_status(mcu_status), .output_port(output_port),
  .kbd_irq_pin(kbd_irq_pin));

// ---- dv/kbhp_host_port_ctrl_bench.sv ----
// Self-checking bench for the keyboard host port controller
`timescale 1ns/1ps
module kbhp_host_port_ctrl_bench;
  import kbhp_pkg::*;
  localparam kbhp_mcu_t err_clr_req = '{err_clr:1'b1, default:0};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  kbhp_host_t host = 12'he00;
  kbhp_mcu_t mcu = '0;
  logic [4:0] ram_idx = 5'h00;
  logic [7:0] in_port = 8'h80;
  logic [7:0] d_o, st, ram_q, in_q, out_port, ibuf, rd;
  logic d_oe_n, cmd, irq;
  logic [10:0] fr;
  logic [1:0] busy, lclk, ldat, clk_oe_n, dat_oe_n;
  logic [7:0] mode_tab [4] = '{8'h04, 8'h10, 8'h00, 8'h08};
  logic [7:0] exp_tab [4] = '{8'h14, 8'h00, 8'h00, 8'h10};
  int n_errors = 0;
  int num_checks = 0;

  kbhp_host_port_ctrl #(.TICK_CYCLES(4), .TIMEOUT_TICKS(8'd100), .RTS_HOLD_TICKS(8'd2)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .host_i(host), .host_d_o(d_o), .host_d_oe_n(d_oe_n),
    .mcu_i(mcu), .mcu_ram_idx(ram_idx), .mcu_ibuf_data(ibuf), .mcu_ibuf_cmd(cmd),
    .mcu_status(st), .mcu_tx_busy(busy), .mcu_ram_rdata(ram_q), .mcu_in_port(in_q),
    .input_port(in_port), .output_port(out_port), .link_clk_i(lclk), .link_clk_o(),
    .link_clk_oe_n(clk_oe_n), .link_dat_i(ldat), .link_dat_o(), .link_dat_oe_n(dat_oe_n),
    .kbd_irq_pin(irq));
  kbhp_link_dev dev_u (.clk_oe_n(clk_oe_n), .dat_oe_n(dat_oe_n), .clk_line(lclk),
    .dat_line(ldat));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wait_st(input int b, input logic v);
    int i;
    i = 0;
    while (st[b] !== v && i < 1500)
    begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 1500)
    begin
      check("status wait", 8'h00, 8'h01);
      close_out();
    end
  endtask
  task automatic mcu_p(input kbhp_mcu_t v);
    @(posedge sys_clk);
    mcu <= v;
    @(posedge sys_clk);
    mcu <= '0;
    @(negedge sys_clk);
  endtask
  task automatic host_rd(input logic a2, output logic [7:0] q);
    @(posedge sys_clk);
    host <= '{cs_n:1'b0, ior_n:1'b0, iow_n:1'b1, a2:a2, d:8'h00};
    cyc(5);
    @(negedge sys_clk);
    check("bus drive", {7'h00, d_oe_n}, 8'h00);
    q = d_o;
    cyc(3);
    host <= '{cs_n:1'b1, ior_n:1'b1, iow_n:1'b1, a2:a2, d:8'h00};
    cyc(8);
  endtask
  task automatic host_wr(input logic cs_n, input logic a2, input logic [7:0] d);
    @(posedge sys_clk);
    host <= '{cs_n:cs_n, ior_n:1'b1, iow_n:1'b0, a2:a2, d:d};
    cyc(7);
    host <= '{cs_n:1'b1, ior_n:1'b1, iow_n:1'b1, a2:a2, d:d};
    cyc(8);
    @(negedge sys_clk);
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    check("out port rst", out_port, 8'h00);
    host_rd(1'b1, rd);
    check("status rst", rd, 8'h10);
    mcu_p('{obuf_wr:1'b1, obuf_data:8'ha5, default:0});
    host_rd(1'b1, rd);
    check("status full", rd, 8'h11);
    host_rd(1'b1, rd);
    check("status again", rd, 8'h11);
    host_rd(1'b0, rd);
    check("data", rd, 8'ha5);
    check("status empty", st, 8'h10);
    mcu_p('{mode_wr:1'b1, wdata:8'h01, default:0});
    mcu_p('{obuf_wr:1'b1, obuf_data:8'h3c, default:0});
    check("irq set", {7'h00, irq}, 8'h01);
    host_rd(1'b0, rd);
    check("irq clear", {7'h00, irq}, 8'h00);
    host_wr(1'b0, 1'b0, 8'h12);
    check("status data wr", st, 8'h12);
    check("ibuf", ibuf, 8'h12);
    mcu_p('{ibuf_rd:1'b1, default:0});
    host_wr(1'b0, 1'b1, 8'hd1);
    check("status cmd wr", st, 8'h1a);
    check("ibuf cmd", {7'h00, cmd}, 8'h01);
    mcu_p('{ibuf_rd:1'b1, default:0});
    host_wr(1'b1, 1'b0, 8'h77);
    check("deselected", st, 8'h18);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk);
      in_port <= k[1] ? 8'h00 : 8'h80;
      mcu_p('{mode_wr:1'b1, wdata:mode_tab[k], default:0});
      cyc(6);
      check("sys kbe", st & 8'h14, exp_tab[k]);
    end
    dev_u.send(0, 8'h96, 1'b1, 11);
    wait_st(ST_OBF, 1'b1);
    host_rd(1'b0, rd);
    check("rx byte", rd, 8'h96);
    dev_u.send(0, 8'h41, 1'b0, 11);
    wait_st(ST_OBF, 1'b1);
    check("parity flag", st & 8'h81, 8'h81);
    host_rd(1'b0, rd);
    check("parity fill", rd, 8'hff);
    mcu_p(err_clr_req);
    dev_u.send(0, 8'h00, 1'b1, 4);
    wait_st(ST_B6, 1'b1);
    check("rx timeout", st & 8'he0, 8'h40);
    mcu_p(err_clr_req);
    mcu_p('{tx_req:2'b01, tx_data:8'h55, default:0});
    check("tx busy", {6'h00, busy}, 8'h01);
    wait_st(ST_B5, 1'b1);
    check("tx timeout", st & 8'he0, 8'h20);
    mcu_p(err_clr_req);
    mcu_p('{tx_req:2'b01, tx_data:8'h55, default:0});
    dev_u.recv(0, fr);
    check("tx frame data", fr[8:1], 8'h55);
    check("tx frame ends", {5'h00, fr[10:9], fr[0]}, 8'h06);
    cyc(4);
    check("tx done", {6'h00, busy} | (st & 8'h20), 8'h00);
    mcu_p('{ctrl_wr:1'b1, wdata:8'hc0, default:0});
    mcu_p('{tx_req:2'b01, tx_data:8'h55, default:0});
    wait_st(ST_B6, 1'b1);
    host_rd(1'b0, rd);
    check("tx timeout fill", rd, 8'hfe);
    mcu_p(err_clr_req);
    dev_u.send(1, 8'h7e, 1'b1, 11);
    wait_st(ST_OBF, 1'b1);
    check("mouse source", st & 8'h21, 8'h21);
    host_rd(1'b0, rd);
    check("mouse byte", rd, 8'h7e);
    mcu_p('{obuf_wr:1'b1, obuf_data:8'h5a, default:0});
    check("kbd source", st & 8'h21, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk);
      ram_idx <= k == 1 ? 5'h00 : 5'h1f;
      mcu_p('{ram_idx_wr:1'b1, default:0});
      if (k < 2)
        mcu_p('{ram_wr:1'b1, wdata:k ? 8'h3c : 8'hc3, default:0});
    end
    mcu_p('{out_port_wr:1'b1, wdata:8'ha7, default:0});
    check("ram", ram_q, 8'hc3);
    check("out port", out_port, 8'ha7);
    check("in port", in_q, 8'h00);
    close_out();
  end
endmodule

// ---- dv/kbhp_link_dev.sv ----
// Keyboard and mouse link device model on pulled-up open-drain lines
`timescale 1ns/1ps
module kbhp_link_dev (
  input wire logic [1:0] clk_oe_n,
  input wire logic [1:0] dat_oe_n,
  output logic [1:0] clk_line,
  output logic [1:0] dat_line
);
  logic [1:0] dev_clk = 2'h3;
  logic [1:0] dev_dat = 2'h3;
  // ==========================================================
  // Wired-and, high when released
  assign clk_line = clk_oe_n & dev_clk;
  assign dat_line = dat_oe_n & dev_dat;
  // ==========================================================
  // Frame sender, clock idles high between frames
  task automatic send(input int ch, input logic [7:0] b, input logic par_ok, input int nbits);
    logic [10:0] f;
    f = {1'b1, par_ok ? ~^b : ^b, b, 1'b0};
    for (int i = 0; i < nbits; i++)
    begin
      dev_dat[ch] = f[i];
      #16;
      dev_clk[ch] = 1'b0;
      #32;
      dev_clk[ch] = 1'b1;
      #16;
    end
    dev_dat[ch] = 1'b1;
  endtask
  // ==========================================================
  // Frame receiver: clocks a controller frame in, then acks
  task automatic recv(input int ch, output logic [10:0] f);
    #200;
    f[0] = dat_line[ch];
    for (int i = 1; i < 11; i++)
    begin
      dev_clk[ch] = 1'b0;
      #32;
      dev_clk[ch] = 1'b1;
      #24;
      f[i] = dat_line[ch];
      #8;
    end
    dev_dat[ch] = 1'b0;
    dev_clk[ch] = 1'b0;
    #32;
    dev_clk[ch] = 1'b1;
    dev_dat[ch] = 1'b1;
    #32;
  endtask
endmodule
